// ### design/ldc_defines.vh
/*
   Constants for the line driver control register bank: register offsets,
   reset values, field positions, current limit values and fault timing.
   Assumes it is included by bare name from every design file that needs it.
*/
`ifndef LDC_DEFINES_VH
`define LDC_DEFINES_VH

// Register port geometry
`define LDC_ADDR_W        3
`define LDC_DATA_W        8
`define LDC_ADDR_LIMIT    3'h3
`define LDC_ADDR_CONFIG   3'h4
`define LDC_LIMIT_RST     8'h00
`define LDC_CONFIG_RST    8'h01
`define LDC_RDATA_NONE    8'h00

// Fields of driver_limit_retry
`define LDC_LIM_SEL_HI    7
`define LDC_LIM_SEL_LO    6
`define LDC_LIM_DIS       5
`define LDC_BLK_SEL_HI    4
`define LDC_BLK_SEL_LO    3
`define LDC_RTY_SEL_HI    2
`define LDC_RTY_SEL_LO    1
`define LDC_RTY_EN        0

// Fields of line_driver_config
`define LDC_CFG_RX_DIS    7
`define LDC_CFG_WPD       6
`define LDC_CFG_WPU       5
`define LDC_CFG_SPARE     4
`define LDC_CFG_LOW_SIDE  3
`define LDC_CFG_PUSH_PULL 2
`define LDC_CFG_STATIC    1
`define LDC_CFG_DRV_DIS   0

// Select codes shared by the two-bit fields
`define LDC_SEL_0         2'h0
`define LDC_SEL_1         2'h1
`define LDC_SEL_2         2'h2
`define LDC_SEL_3         2'h3

// Current limit in mA reported for each select code
`define LDC_ILIM0_MA      8'h32
`define LDC_ILIM1_MA      8'h64
`define LDC_ILIM2_MA      8'hc8
`define LDC_ILIM3_MA      8'hfa

// Clock rate and fault times in their printed units
`define LDC_CLK_MHZ       50
`define LDC_US_PER_MS     1000
`define LDC_BLANK0_US     128
`define LDC_BLANK1_US     500
`define LDC_BLANK2_MS     1
`define LDC_BLANK3_MS     5
`define LDC_RETRY0_MS     50
`define LDC_RETRY1_MS     100
`define LDC_RETRY2_MS     200
`define LDC_RETRY3_MS     500

// Fault timer counter
`define LDC_CNT_W         25
`define LDC_CNT_ZERO      25'h0
`define LDC_CNT_ONE       25'h1
`define LDC_ST_W          2

`endif

// ### design/ldc_fault_timer.v
/*
   Fault timer for the line driver: blanking of overcurrent and thermal
   conditions, driver shut-off, auto-retry off-time or thermal recovery.
   Assumes fault sense inputs are synchronous to the clock and that the
   parent passes cycle counts of at least one.
*/
`timescale 1ns/100ps
`include "ldc_defines.vh"

module ldc_fault_timer #(
   parameter integer BLANK0_CYC = 6400,
   parameter integer BLANK1_CYC = 25000,
   parameter integer BLANK2_CYC = 50000,
   parameter integer BLANK3_CYC = 250000,
   parameter integer RETRY0_CYC = 2500000,
   parameter integer RETRY1_CYC = 5000000,
   parameter integer RETRY2_CYC = 10000000,
   parameter integer RETRY3_CYC = 25000000
) (
   // Clock, reset, enable
   input  wire       i_clk,
   input  wire       i_srst,
   input  wire       i_ce,
   // Sense and configuration
   input  wire       i_fault_cond,
   input  wire       i_temp_recovered,
   input  wire       i_retry_en,
   input  wire [1:0] i_blank_sel,
   input  wire [1:0] i_retry_sel,
   // Results
   output wire       o_driver_off,
   output wire       o_fault_flag
);

   // Binary state codes
   localparam [`LDC_ST_W-1:0] ST_RUN   = 2'h0;  // Driver allowed
   localparam [`LDC_ST_W-1:0] ST_BLANK = 2'h1;  // Condition seen, blanking
   localparam [`LDC_ST_W-1:0] ST_OFF   = 2'h2;  // Driver shut off

   reg  [`LDC_ST_W-1:0] state_r;      // Current state
   reg  [`LDC_ST_W-1:0] state_nxt;    // Next state
   reg  [`LDC_CNT_W-1:0] cnt_r;       // Blanking or off-time counter
   reg  [`LDC_CNT_W-1:0] cnt_nxt;     // Next counter value
   reg                   off_r;       // Registered shut-off
   reg                   flag_r;      // Registered fault flag
   reg                   fault_evt;   // Blanking ran out this cycle
   reg  [31:0]           blank_cyc;   // Selected blanking length
   reg  [31:0]           retry_cyc;   // Selected off-time length
   wire [`LDC_CNT_W-1:0] blank_end;   // Last count of blanking
   wire [`LDC_CNT_W-1:0] retry_end;   // Last count of off-time

   // Select blanking length from the two-bit code
   always @* begin
      case (i_blank_sel)
         `LDC_SEL_0: blank_cyc = BLANK0_CYC;
         `LDC_SEL_1: blank_cyc = BLANK1_CYC;
         `LDC_SEL_2: blank_cyc = BLANK2_CYC;
         default:    blank_cyc = BLANK3_CYC;
      endcase
   end

   // Select auto-retry off-time from the two-bit code
   always @* begin
      case (i_retry_sel)
         `LDC_SEL_0: retry_cyc = RETRY0_CYC;
         `LDC_SEL_1: retry_cyc = RETRY1_CYC;
         `LDC_SEL_2: retry_cyc = RETRY2_CYC;
         default:    retry_cyc = RETRY3_CYC;
      endcase
   end

   assign blank_end = blank_cyc[`LDC_CNT_W-1:0] - `LDC_CNT_ONE;
   assign retry_end = retry_cyc[`LDC_CNT_W-1:0] - `LDC_CNT_ONE;

   // Next state: count condition cycles, shut off, then recover
   always @* begin
      state_nxt = state_r;
      cnt_nxt   = cnt_r;
      fault_evt = 1'b0;
      case (state_r)
         ST_RUN: begin
            // First cycle of the condition counts as one
            if (i_fault_cond) begin
               if (blank_end == `LDC_CNT_ZERO) begin
                  state_nxt = ST_OFF;
                  fault_evt = 1'b1;
               end else begin
                  state_nxt = ST_BLANK;
                  cnt_nxt   = `LDC_CNT_ONE;
               end
            end
         end
         ST_BLANK: begin
            if (!i_fault_cond) begin
               // Condition vanished early: restart, no fault
               state_nxt = ST_RUN;
               cnt_nxt   = `LDC_CNT_ZERO;
            end else if (cnt_r >= blank_end) begin
               state_nxt = ST_OFF;
               cnt_nxt   = `LDC_CNT_ZERO;
               fault_evt = 1'b1;
            end else begin
               cnt_nxt = cnt_r + `LDC_CNT_ONE;
            end
         end
         ST_OFF: begin
            if (i_retry_en) begin
               // Fixed off-time, then back on without software
               if (cnt_r >= retry_end) begin
                  state_nxt = ST_RUN;
                  cnt_nxt   = `LDC_CNT_ZERO;
               end else begin
                  cnt_nxt = cnt_r + `LDC_CNT_ONE;
               end
            end else if (i_temp_recovered) begin
               state_nxt = ST_RUN;
               cnt_nxt   = `LDC_CNT_ZERO;
            end
         end
         default: begin
            state_nxt = ST_RUN;
            cnt_nxt   = `LDC_CNT_ZERO;
         end
      endcase
   end

   // State registers; flag follows the condition once raised
   always @(posedge i_clk) begin
      if (i_srst) begin
         state_r <= ST_RUN;
         cnt_r   <= `LDC_CNT_ZERO;
         off_r   <= 1'b0;
         flag_r  <= 1'b0;
      end else if (i_ce) begin
         state_r <= state_nxt;
         cnt_r   <= cnt_nxt;
         off_r   <= (state_nxt == ST_OFF);
         flag_r  <= fault_evt | (flag_r & i_fault_cond);
      end
   end

   assign o_driver_off = off_r;
   assign o_fault_flag = flag_r;

endmodule // ldc_fault_timer

// ### design/ldc_top.v
/*
   Line driver control: two configuration registers behind a byte-wide
   register port, the decode of the line driver switches, receiver and
   weak pulls, and the fault timer that shuts the driver off.
   Assumes all inputs are synchronous to I_CLOCK, that the analog front end
   reports overcurrent, overtemperature and thermal recovery as levels, and
   that the polarity invert bit is supplied by a register outside this block.
*/
// Overview of operation
// - Select field picks 50/100/200/250mA limit
// - Limit-disable bit turns current limiting off
// - Blanking time selectable before fault is signalled
// - Off-time field picks 50/100/200/500ms
// - Auto-retry: off for fixed time, then on
// - No retry: off until temperature recovers
// - Receiver-disable bit floats receive output
// - Weak pull-down bit switches current sink
// - Weak pull-up bit switches current source
// - Open-drain polarity: 1 low-side, 0 high-side
// - Push-pull bit selects push-pull or open-drain
// - Static level 1 drives line active
// - Static 0: float unless enabled and not disabled
// - Enabled driver sends inverse of transmit data
// - Driver-disable bit floats driver always
// - All config bits read/write, reads harmless
// - Invert bit chooses inverted or direct transmit
// - Fault flag set on fault, clears itself
`timescale 1ns/100ps
`include "ldc_defines.vh"

module ldc_top #(
   // Fault timing in cycles; shorten these for simulation
   parameter integer BLANK0_CYC = `LDC_BLANK0_US * `LDC_CLK_MHZ,
   parameter integer BLANK1_CYC = `LDC_BLANK1_US * `LDC_CLK_MHZ,
   parameter integer BLANK2_CYC = `LDC_BLANK2_MS * `LDC_US_PER_MS * `LDC_CLK_MHZ,
   parameter integer BLANK3_CYC = `LDC_BLANK3_MS * `LDC_US_PER_MS * `LDC_CLK_MHZ,
   parameter integer RETRY0_CYC = `LDC_RETRY0_MS * `LDC_US_PER_MS * `LDC_CLK_MHZ,
   parameter integer RETRY1_CYC = `LDC_RETRY1_MS * `LDC_US_PER_MS * `LDC_CLK_MHZ,
   parameter integer RETRY2_CYC = `LDC_RETRY2_MS * `LDC_US_PER_MS * `LDC_CLK_MHZ,
   parameter integer RETRY3_CYC = `LDC_RETRY3_MS * `LDC_US_PER_MS * `LDC_CLK_MHZ
) (
   // Clock, reset and clock enable
   input  wire                   I_CLOCK,
   input  wire                   I_SRST,
   input  wire                   I_CE,
   // Register port
   input  wire [`LDC_ADDR_W-1:0] I_REG_ADDR,
   input  wire                   I_REG_WR,
   input  wire [`LDC_DATA_W-1:0] I_REG_WDATA,
   input  wire                   I_REG_RD,
   output wire [`LDC_DATA_W-1:0] O_REG_RDATA,
   output wire                   O_REG_RVALID,
   // Microcontroller pins
   input  wire                   I_TX,
   input  wire                   I_TRANSMIT_ENABLE_PIN,
   input  wire                   I_POLARITY_INVERT,
   output wire                   O_RX,
   output wire                   O_RX_OE,
   // Analog front end sense
   input  wire                   I_LINE_LEVEL,
   input  wire                   I_OVERCURRENT,
   input  wire                   I_OVERTEMP,
   input  wire                   I_TEMP_RECOVERED,
   // Line driver controls
   output wire                   O_HIGH_SIDE_ON,
   output wire                   O_LOW_SIDE_ON,
   output wire                   O_LIMIT_ENABLE,
   output wire [7:0]             O_LIMIT_MA,
   output wire                   O_WEAK_PULLUP_ON,
   output wire                   O_WEAK_PULLDOWN_ON,
   // Status
   output wire                   O_DRIVER_FAULT_FLAG,
   output wire                   O_DRIVER_OFF
);

   // Configuration registers
   reg  [`LDC_DATA_W-1:0] limit_retry_r;    // driver_limit_retry
   reg  [`LDC_DATA_W-1:0] limit_retry_nxt;  // Its next value
   reg  [`LDC_DATA_W-1:0] drv_config_r;     // line_driver_config
   reg  [`LDC_DATA_W-1:0] drv_config_nxt;   // Its next value

   // Read port
   reg  [`LDC_DATA_W-1:0] rdata_r;          // Read data holding register
   reg  [`LDC_DATA_W-1:0] rdata_nxt;        // Data selected by address
   reg                    rvalid_r;         // One-cycle read answer

   // Registered pin and control outputs
   reg                    hs_on_r;          // High-side switch on
   reg                    hs_on_nxt;
   reg                    ls_on_r;          // Low-side switch on
   reg                    ls_on_nxt;
   reg                    rx_r;             // Receive data
   reg                    rx_nxt;
   reg                    rx_oe_r;          // Receive pin driven
   reg                    lim_en_r;         // Current limit active
   reg  [7:0]             lim_ma_r;         // Current limit in mA
   reg  [7:0]             lim_ma_nxt;
   reg                    wpu_r;            // Weak source on
   reg                    wpd_r;            // Weak sink on

   // Driver decode helpers
   reg                    drive_active;     // Driver forces the line
   reg                    drive_level;      // Level when active
   wire                   fault_off;        // Fault timer holds off
   wire                   fault_flag;       // Fault status from timer
   wire                   fault_cond;       // Overcurrent or thermal

   // Field views of the registers
   wire [1:0] limit_sel  = {limit_retry_r[`LDC_LIM_SEL_HI],
                            limit_retry_r[`LDC_LIM_SEL_LO]};
   wire       limit_dis  = limit_retry_r[`LDC_LIM_DIS];
   wire [1:0] blank_sel  = {limit_retry_r[`LDC_BLK_SEL_HI],
                            limit_retry_r[`LDC_BLK_SEL_LO]};
   wire [1:0] retry_sel  = {limit_retry_r[`LDC_RTY_SEL_HI],
                            limit_retry_r[`LDC_RTY_SEL_LO]};
   wire       retry_en   = limit_retry_r[`LDC_RTY_EN];
   wire       rx_dis     = drv_config_r[`LDC_CFG_RX_DIS];
   wire       wpd_bit    = drv_config_r[`LDC_CFG_WPD];
   wire       wpu_bit    = drv_config_r[`LDC_CFG_WPU];
   wire       low_side   = drv_config_r[`LDC_CFG_LOW_SIDE];
   wire       push_pull  = drv_config_r[`LDC_CFG_PUSH_PULL];
   wire       static_lvl = drv_config_r[`LDC_CFG_STATIC];
   wire       drv_dis    = drv_config_r[`LDC_CFG_DRV_DIS];

   // Write decode; every bit is stored, the spare bit included
   always @* begin
      limit_retry_nxt = limit_retry_r;
      drv_config_nxt  = drv_config_r;
      if (I_REG_WR) begin
         case (I_REG_ADDR)
            `LDC_ADDR_LIMIT:  limit_retry_nxt = I_REG_WDATA;
            `LDC_ADDR_CONFIG: drv_config_nxt  = I_REG_WDATA;
            default: begin
               // Writes elsewhere are dropped
               limit_retry_nxt = limit_retry_r;
               drv_config_nxt  = drv_config_r;
            end
         endcase
      end
   end

   // Read mux; a read only copies, it never alters a register
   always @* begin
      case (I_REG_ADDR)
         `LDC_ADDR_LIMIT:  rdata_nxt = limit_retry_r;
         `LDC_ADDR_CONFIG: rdata_nxt = drv_config_r;
         default:          rdata_nxt = `LDC_RDATA_NONE;   // Unmapped reads zero
      endcase
   end

   // Register file and read answer
   always @(posedge I_CLOCK) begin
      if (I_SRST) begin
         limit_retry_r <= `LDC_LIMIT_RST;
         drv_config_r  <= `LDC_CONFIG_RST;  // Driver disabled at power-up
         rdata_r       <= `LDC_RDATA_NONE;
         rvalid_r      <= 1'b0;
      end else if (I_CE) begin
         limit_retry_r <= limit_retry_nxt;
         drv_config_r  <= drv_config_nxt;
         rvalid_r      <= I_REG_RD;
         if (I_REG_RD) begin
            rdata_r <= rdata_nxt;  // Held until the next read
         end
      end
   end

   // Fault sense: either condition starts the blanking window
   assign fault_cond = I_OVERCURRENT | I_OVERTEMP;

   // Blanking, shut-off and recovery timing
   ldc_fault_timer #(
      .BLANK0_CYC (BLANK0_CYC),
      .BLANK1_CYC (BLANK1_CYC),
      .BLANK2_CYC (BLANK2_CYC),
      .BLANK3_CYC (BLANK3_CYC),
      .RETRY0_CYC (RETRY0_CYC),
      .RETRY1_CYC (RETRY1_CYC),
      .RETRY2_CYC (RETRY2_CYC),
      .RETRY3_CYC (RETRY3_CYC)
   ) u_fault_timer (
      .i_clk            (I_CLOCK),
      .i_srst           (I_SRST),
      .i_ce             (I_CE),
      .i_fault_cond     (fault_cond),
      .i_temp_recovered (I_TEMP_RECOVERED),
      .i_retry_en       (retry_en),
      .i_blank_sel      (blank_sel),
      .i_retry_sel      (retry_sel),
      .o_driver_off     (fault_off),
      .o_fault_flag     (fault_flag)
   );

   // Decide whether the driver forces the line and to which level.
   // Disable and fault shut-off win over the static bit so that a
   // faulted or disabled driver can never be turned on by software.
   always @* begin
      drive_active = 1'b0;
      drive_level  = 1'b0;
      if (drv_dis || fault_off) begin
         // Both switches stay open
         drive_active = 1'b0;
      end else if (static_lvl) begin
         drive_active = 1'b1;
         drive_level  = 1'b1;
      end else if (I_TRANSMIT_ENABLE_PIN) begin
         drive_active = 1'b1;
         // Inverted transmit unless the invert bit asks for direct
         drive_level  = I_POLARITY_INVERT ? I_TX : ~I_TX;
      end else begin
         drive_active = 1'b0;
      end
   end

   // Map level to switches for push-pull, high-side and low-side modes
   always @* begin
      hs_on_nxt = 1'b0;
      ls_on_nxt = 1'b0;
      if (drive_active) begin
         if (push_pull) begin
            // Polarity bit has no say in push-pull
            hs_on_nxt = drive_level;
            ls_on_nxt = ~drive_level;
         end else if (low_side) begin
            // Level high means the sink switch is open
            ls_on_nxt = ~drive_level;
         end else begin
            hs_on_nxt = drive_level;
         end
      end
   end

   // Current limit value from the select code
   always @* begin
      case (limit_sel)
         `LDC_SEL_0: lim_ma_nxt = `LDC_ILIM0_MA;
         `LDC_SEL_1: lim_ma_nxt = `LDC_ILIM1_MA;
         `LDC_SEL_2: lim_ma_nxt = `LDC_ILIM2_MA;
         default:    lim_ma_nxt = `LDC_ILIM3_MA;
      endcase
   end

   // Receive data follows the same invert choice as transmit
   always @* begin
      rx_nxt = I_POLARITY_INVERT ? I_LINE_LEVEL : ~I_LINE_LEVEL;
   end

   // Output flip-flops; all controls follow the registers one edge later.
   // The extra edge also delays transmit data by one cycle, which is far
   // below any line bit time.
   always @(posedge I_CLOCK) begin
      if (I_SRST) begin
         hs_on_r  <= 1'b0;
         ls_on_r  <= 1'b0;
         rx_r     <= 1'b0;
         rx_oe_r  <= 1'b0;
         lim_en_r <= 1'b0;
         lim_ma_r <= `LDC_ILIM0_MA;
         wpu_r    <= 1'b0;
         wpd_r    <= 1'b0;
      end else if (I_CE) begin
         hs_on_r  <= hs_on_nxt;
         ls_on_r  <= ls_on_nxt;
         rx_r     <= rx_nxt;
         rx_oe_r  <= ~rx_dis;
         lim_en_r <= ~limit_dis;
         lim_ma_r <= lim_ma_nxt;
         wpu_r    <= wpu_bit;
         wpd_r    <= wpd_bit;
      end
   end

   // Port drives
   assign O_REG_RDATA         = rdata_r;
   assign O_REG_RVALID        = rvalid_r;
   assign O_RX                = rx_r;
   assign O_RX_OE             = rx_oe_r;
   assign O_HIGH_SIDE_ON      = hs_on_r;
   assign O_LOW_SIDE_ON       = ls_on_r;
   assign O_LIMIT_ENABLE      = lim_en_r;
   assign O_LIMIT_MA          = lim_ma_r;
   assign O_WEAK_PULLUP_ON    = wpu_r;
   assign O_WEAK_PULLDOWN_ON  = wpd_r;
   assign O_DRIVER_FAULT_FLAG = fault_flag;
   assign O_DRIVER_OFF        = fault_off;

endmodule // ldc_top

// ### sim/ldc_line_model.sv
/*
   Far side of the line: resolves the sensor line from switches and weak pulls.
   Assumes one clock; a line left floating shows a pattern changing every cycle.
*/
`timescale 1ns/100ps

module ldc_line_model (
   // Clock
   input  wire i_clk,
   // Driver controls from the block
   input  wire i_hs,
   input  wire i_ls,
   input  wire i_wpu,
   input  wire i_wpd,
   // Resolved line level
   output reg  o_line
);
   reg toggle_r = 1'b0;  // Floating pattern, so no stale level is mistaken for a drive

   // Floating pattern flips each cycle
   always @(posedge i_clk) begin
      toggle_r <= ~toggle_r;
   end

   // Strong switches win over weak pulls; pull-up wins if both pulls are on
   always @* begin
      o_line = i_hs ? 1'b1 : i_ls ? 1'b0 : i_wpu ? 1'b1 : i_wpd ? 1'b0 : toggle_r;
   end
endmodule // ldc_line_model

// ### sim/ldc_chk_properties.sv
/*
   Port checker of the line driver control block.
   Assumes it is bound to ldc_top and that I_CLOCK is the only clock.
*/
`timescale 1ns/100ps
`include "ldc_defines.vh"

module ldc_chk_properties (
   // Clock and control
   input wire       I_CLOCK,
   input wire       I_SRST,
   input wire       I_CE,
   input wire       I_REG_RD,
   input wire       I_POLARITY_INVERT,
   input wire       I_LINE_LEVEL,
   input wire       I_OVERCURRENT,
   input wire       I_OVERTEMP,
   // Watched outputs
   input wire       O_REG_RVALID,
   input wire       O_RX,
   input wire       O_RX_OE,
   input wire       O_HIGH_SIDE_ON,
   input wire       O_LOW_SIDE_ON,
   input wire [7:0] O_LIMIT_MA,
   input wire       O_DRIVER_FAULT_FLAG,
   input wire       O_DRIVER_OFF
);
   wire cnd  = I_OVERCURRENT | I_OVERTEMP;  // Fault condition as the timer sees it
   wire take = I_REG_RD & I_CE;             // Read taken at this edge

   default clocking cb @(posedge I_CLOCK); endclocking
   default disable iff (I_SRST);

   // Condition gone for two enabled cycles
   sequence s_cond_gone;
      (!cnd && I_CE) ##1 (!cnd && I_CE);
   endsequence

   a_read_answer: assert property (take |=> O_REG_RVALID)
      else $error("read not answered");
   a_rvalid_cause: assert property (O_REG_RVALID |-> $past(take))
      else $error("read valid without read");
   a_limit_code: assert property (O_LIMIT_MA inside {`LDC_ILIM0_MA, `LDC_ILIM1_MA,
      `LDC_ILIM2_MA, `LDC_ILIM3_MA}) else $error("illegal limit value");
   a_switch_exclusive: assert property (!(O_HIGH_SIDE_ON && O_LOW_SIDE_ON))
      else $error("both switches on");
   a_off_kills_drive: assert property (O_DRIVER_OFF && I_CE |=>
      !O_HIGH_SIDE_ON && !O_LOW_SIDE_ON) else $error("driver on during shut-off");
   a_blank_min: assert property ($rose(O_DRIVER_OFF) |->
      $past(cnd, 3) && $past(cnd, 2) && $past(cnd)) else $error("shut-off before blanking");
   a_flag_with_off: assert property ($rose(O_DRIVER_OFF) |-> O_DRIVER_FAULT_FLAG)
      else $error("shut-off without fault flag");
   a_flag_clears: assert property (s_cond_gone |=> !O_DRIVER_FAULT_FLAG)
      else $error("fault flag not cleared");
   a_rx_follows: assert property (O_RX_OE && $past(I_CE) && !$past(I_SRST) |->
      O_RX == ($past(I_LINE_LEVEL) ~^ $past(I_POLARITY_INVERT))) else $error("rx wrong");
endmodule // ldc_chk_properties

// ### sim/tb.sv
/*
   Self-checking bench of ldc_top: registers, limit, pulls, driver, fault timing.
   Assumes shortened fault counts and the line model on the far side.
*/
`timescale 1ns/100ps
`include "ldc_defines.vh"

module tb;
   logic       clk = 1'b0, srst = 1'b1, ce = 1'b1;         // Clock, reset, enable
   logic [2:0] addr = 3'h0;                                 // Register address
   logic       wr = 1'b0, rd = 1'b0;                        // Strobes
   logic [7:0] wdata = 8'h00;                               // Write data
   logic       tx = 1'b0, transmit_enable_pin = 1'b0, inv = 1'b0;          // Microcontroller pins
   logic       oc = 1'b0, ot = 1'b0, trec = 1'b0;           // Front end sense
   wire  [7:0] rdata, lim_ma;
   wire        rvalid, rx, rxoe, hs, ls, lim_en, wpu, wpd, flag, off, line;
   int         bad_count = 0, cmp_count = 0, n, m;
   logic [7:0] lim_tab [0:3] = '{`LDC_ILIM0_MA, `LDC_ILIM1_MA, `LDC_ILIM2_MA, `LDC_ILIM3_MA};
   int blk_tab [0:3] = '{`LDC_BLANK0_US*`LDC_CLK_MHZ, `LDC_BLANK1_US*`LDC_CLK_MHZ,
      `LDC_BLANK2_MS*`LDC_US_PER_MS*`LDC_CLK_MHZ, 3};  // Only code 3 shortened
   int rty_tab [0:3] = '{10, 12, 14, 16};  // Shortened off-times
   // Config, then transmit_enable_pin, tx, invert, expected high side, low side
   logic [12:0] drv_tab [0:12] = '{{8'h04,5'b10010}, {8'h04,5'b11001}, {8'h04,5'b00000},
      {8'h06,5'b00010}, {8'h00,5'b10010}, {8'h00,5'b11000}, {8'h08,5'b11001},
      {8'h08,5'b10000}, {8'h0a,5'b00000}, {8'h0c,5'b11001}, {8'h05,5'b10000},
      {8'h07,5'b00000}, {8'h04,5'b11110}};

   always #10 clk = ~clk;

   ldc_top #(.BLANK3_CYC(3),
      .RETRY0_CYC(10), .RETRY1_CYC(12), .RETRY2_CYC(14), .RETRY3_CYC(16)) dut_u (
      .I_CLOCK(clk), .I_SRST(srst), .I_CE(ce), .I_REG_ADDR(addr), .I_REG_WR(wr),
      .I_REG_WDATA(wdata), .I_REG_RD(rd), .O_REG_RDATA(rdata), .O_REG_RVALID(rvalid),
      .I_TX(tx), .I_TRANSMIT_ENABLE_PIN(transmit_enable_pin), .I_POLARITY_INVERT(inv), .O_RX(rx),
      .O_RX_OE(rxoe), .I_LINE_LEVEL(line), .I_OVERCURRENT(oc), .I_OVERTEMP(ot),
      .I_TEMP_RECOVERED(trec), .O_HIGH_SIDE_ON(hs), .O_LOW_SIDE_ON(ls),
      .O_LIMIT_ENABLE(lim_en), .O_LIMIT_MA(lim_ma), .O_WEAK_PULLUP_ON(wpu),
      .O_WEAK_PULLDOWN_ON(wpd), .O_DRIVER_FAULT_FLAG(flag), .O_DRIVER_OFF(off));

   ldc_line_model line_u (.i_clk(clk), .i_hs(hs), .i_ls(ls), .i_wpu(wpu), .i_wpd(wpd),
      .o_line(line));

   // Inputs always move the same small delay after the rising edge
   task tick;
      @(posedge clk);
      #2;
   endtask

   task results;
      $display("compares %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask

   task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp) begin
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
         bad_count++;
      end
   endtask

   // Bounded wait for the shut-off level; running out ends the run
   task wait_off(input logic v, input int lim, output int k);
      k = 0;
      while (off !== v && k < lim) begin
         tick();
         k++;
      end
      if (off !== v) begin
         $display("CHECK FAILED shut_off_wait expected %b seen %b", v, off);
         bad_count++;
         results();
      end
   endtask

   // Write lands at the first edge, controls follow at the second
   task wr_reg(input logic [2:0] a, input logic [7:0] d);
      addr = a;
      wdata = d;
      wr = 1'b1;
      tick();
      wr = 1'b0;
      tick();
   endtask

   task rd_reg(input logic [2:0] a, input logic [7:0] exp);
      addr = a;
      rd = 1'b1;
      tick();
      rd = 1'b0;
      chk("read_valid", 1, rvalid);
      chk("read_data", exp, rdata);
      tick();
   endtask

   task t_regs;
      rd_reg(`LDC_ADDR_LIMIT, `LDC_LIMIT_RST);
      rd_reg(`LDC_ADDR_CONFIG, `LDC_CONFIG_RST);
      rd_reg(3'h7, `LDC_RDATA_NONE);
      wr_reg(`LDC_ADDR_CONFIG, 8'h10);
      rd_reg(`LDC_ADDR_CONFIG, 8'h10);
      rd_reg(`LDC_ADDR_CONFIG, 8'h10);
      $display("test registers done");
   endtask

   task t_limit;
      for (int i = 0; i < 4; i++) begin
         wr_reg(`LDC_ADDR_LIMIT, {i[1:0], 6'h00});
         chk("limit_ma", lim_tab[i], lim_ma);
         chk("limit_on", 1, lim_en);
      end
      wr_reg(`LDC_ADDR_LIMIT, 8'h20);
      chk("limit_on", 0, lim_en);
      $display("test limit done");
   endtask

   task t_pulls;
      wr_reg(`LDC_ADDR_CONFIG, 8'h40);
      chk("pulls", 1, {wpu, wpd});
      wr_reg(`LDC_ADDR_CONFIG, 8'h20);
      tick();
      chk("pulls", 2, {wpu, wpd});
      chk("rx_pulled_high", 0, rx);
      wr_reg(`LDC_ADDR_CONFIG, 8'ha0);
      chk("rx_driven", 0, rxoe);
      $display("test pulls done");
   endtask

   task t_drive;
      for (int i = 0; i < 13; i++) begin
         wr_reg(`LDC_ADDR_CONFIG, drv_tab[i][12:5]);
         {transmit_enable_pin, tx, inv} = drv_tab[i][4:2];
         tick();
         chk("switches", drv_tab[i][1:0], {hs, ls});
      end
      {transmit_enable_pin, tx, inv} = 3'h4;  // Driver on, so shut-off has something to stop
      $display("test drive done");
   endtask

   task t_glitch;
      wr_reg(`LDC_ADDR_LIMIT, 8'h19);
      ot = 1'b1;
      repeat (2) tick();
      ot = 1'b0;
      tick();
      oc = 1'b1;
      repeat (2) tick();
      oc = 1'b0;
      repeat (3) tick();
      chk("glitch_off", 0, {off, flag});
      $display("test glitch done");
   endtask

   task t_fault;
      for (int i = 0; i < 4; i++) begin
         wr_reg(`LDC_ADDR_LIMIT, {3'h0, i[1:0], i[1:0], 1'b1});
         oc = 1'b1;
         wait_off(1'b1, 60000, n);
         chk("blank_cycles", blk_tab[i], n);
         chk("fault_flag", 1, flag);
         oc = 1'b0;
         wait_off(1'b0, 40, m);
         chk("off_cycles", rty_tab[i], m);
         chk("fault_flag", 0, flag);
      end
      $display("test fault retry done");
   endtask

   task t_noretry;
      wr_reg(`LDC_ADDR_LIMIT, 8'h18);
      ot = 1'b1;
      wait_off(1'b1, 20, n);
      ot = 1'b0;
      repeat (30) tick();
      chk("held_off", 1, off);
      trec = 1'b1;
      ce = 1'b0;
      repeat (3) tick();
      chk("frozen_off", 1, off);
      ce = 1'b1;
      wait_off(1'b0, 3, n);
      trec = 1'b0;
      $display("test no retry done");
   endtask

   initial begin
      repeat (2) tick();
      srst = 1'b0;
      t_regs();
      t_limit();
      t_pulls();
      t_drive();
      t_glitch();
      t_fault();
      t_noretry();
      results();
   end
endmodule // tb

bind ldc_top ldc_chk_properties chk_u (.I_CLOCK(I_CLOCK), .I_SRST(I_SRST), .I_CE(I_CE),
   .I_REG_RD(I_REG_RD), .I_POLARITY_INVERT(I_POLARITY_INVERT), .I_LINE_LEVEL(I_LINE_LEVEL),
   .I_OVERCURRENT(I_OVERCURRENT), .I_OVERTEMP(I_OVERTEMP), .O_REG_RVALID(O_REG_RVALID),
   .O_RX(O_RX), .O_RX_OE(O_RX_OE), .O_HIGH_SIDE_ON(O_HIGH_SIDE_ON),
   .O_LOW_SIDE_ON(O_LOW_SIDE_ON), .O_LIMIT_MA(O_LIMIT_MA),
   .O_DRIVER_FAULT_FLAG(O_DRIVER_FAULT_FLAG), .O_DRIVER_OFF(O_DRIVER_OFF));
